// ===== hdl/fsc_pkg.sv
// Purpose: Shared constants for the frame synced configuration shadow
// Assumes: 9-bit register index, 16-bit register data
// Notes: Offsets are register indices as seen by the serial host port
package fsc_pkg;
  localparam int ADDR_W = 9;
  localparam int DATA_W = 16;
  // Register indices
  localparam logic [8:0] ADDR_BLACK_FIRST = 9'h080;
  localparam logic [8:0] ADDR_BLACK_LAST = 9'h087;
  localparam logic [8:0] ADDR_TEST_FIRST = 9'h090;
  localparam logic [8:0] ADDR_TEST_LAST = 9'h096;
  localparam logic [8:0] ADDR_SEQ_CTRL = 9'h0c0;
  localparam logic [8:0] ADDR_ACTIVE_WINDOW_SELECT = 9'h0c3;
  localparam logic [8:0] ADDR_DARK_ROW_COUNT = 9'h0c5;
  localparam logic [8:0] ADDR_PADDING_ROW_COUNT = 9'h0c6;
  localparam logic [8:0] ADDR_ROW_LENGTH = 9'h0c8;
  localparam logic [8:0] ADDR_GAIN_LAT_CTRL = 9'h0c7;
  localparam logic [8:0] ADDR_TIMER_MULT = 9'h0c9;
  localparam logic [8:0] ADDR_FRAME_PERIOD = 9'h0ca;
  localparam logic [8:0] ADDR_EXPOSURE_SETTING = 9'h0cb;
  localparam logic [8:0] ADDR_GAIN_SETTING = 9'h0cc;
  localparam logic [8:0] ADDR_UPDATE_FREEZE_CONTROL = 9'h0ce;
  localparam logic [8:0] ADDR_STATUS = 9'h0cf;
  localparam logic [8:0] ADDR_ROW_ADDR = 9'h0e6;
  localparam logic [8:0] ADDR_LAST_ROW = 9'h0e7;
  localparam logic [8:0] ADDR_DECIMATION_MODE = 9'h0e8;
  localparam logic [8:0] ADDR_WINDOW_FIRST = 9'h100;
  localparam logic [8:0] ADDR_WINDOW_LAST = 9'h107;
  // Array sizes
  localparam int N_MISC = 15;
  localparam int N_WIN = 8;
  localparam logic [3:0] MISC_TEST_BASE = 4'h8;
  // Field positions
  localparam int SEQ_EN_BIT = 0;
  localparam int BLANK_ROI_BIT = 9;
  localparam int GAIN_LAT_BIT = 13;
  localparam int SYNC_ROW_LEN_BIT = 0;
  localparam int SYNC_DARK_BIT = 1;
  localparam int SYNC_PAD_BIT = 2;
  localparam int SYNC_EXP_BIT = 3;
  localparam int SYNC_GAIN_BIT = 4;
  localparam int SYNC_ROI_BIT = 5;
  // Reset values
  localparam logic [15:0] FREEZE_RESET = 16'h003f;
  localparam logic [15:0] REG_RESET = 16'h0000;
endpackage

// ===== hdl/fsc_shadow_stage.sv
// Purpose: One group of pending settings copied to an active set at frame start
// Assumes: frame_start_in is a one-cycle pulse on clock_in
// Notes: While follow is low the active copy stays frozen
`timescale 1ns/1ps
`default_nettype none
module fsc_shadow_stage #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic reset_in,
  // Control
  input wire logic frame_start_in,
  input wire logic follow_in,
  // Data
  input wire logic [WIDTH-1:0] pending_in,
  output logic [WIDTH-1:0] active_out
);
  // Copy all pending fields together so a group never mixes old and new
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      active_out <= '0;
    end else if (frame_start_in && follow_in) begin
      active_out <= pending_in;
    end
  end
endmodule
`default_nettype wire

// ===== hdl/fsc_config_shadow.sv
// Purpose: Register bank whose written values, except window words and sequencer enable, reach the sequencer at frame boundaries
// Assumes: Register port and frame start come from logic on clock_in
// Notes: Written values are kept as pending; the active set feeds the sequencer
//
// How it works
// - Black-level regs may upset a few frames
// - Sync-code regs take effect next frame
// - Test-pattern regs may corrupt one frame
// - Frame parameters change only at frame start
// - Slow-settling change blanks frame, sends training
// - Decimation applies at frame start, blanks one
// - Dark or padding row change blanks one
// - ROI switch blanks frame only if enabled
// - Only new window selection counts as switch
// - Exposure changes never blank a frame
// - Gain at frame start, optional extra frame
// - Freeze controls live at register 206
// - Frozen group ignores new written values
// - Re-enabled group transfers all pending together
// - Frozen row length keeps previous value
// - Frozen dark/padding rows keep previous counts
// - Frozen exposure group keeps timer, period, exposure
// - Frozen gain keeps both gain fields
// - Frozen ROI keeps selection, decimation, addresses
// - Window dimensions never frozen
`timescale 1ns/1ps
`default_nettype none
module fsc_config_shadow
  import fsc_pkg::*;
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic reset_in,
  // Register port from the serial host interface
  input wire logic [fsc_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [fsc_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [fsc_pkg::DATA_W-1:0] reg_rdata_out,
  output logic reg_rvalid_out,
  // Frame sequencer
  input wire logic frame_start_in,
  output logic seq_enable_out,
  output logic blank_frame_out,
  // Active settings
  output logic [15:0] row_length_out,
  output logic [15:0] dark_rows_out,
  output logic [15:0] padding_rows_out,
  output logic [15:0] timer_mult_out,
  output logic [15:0] frame_period_out,
  output logic [15:0] exposure_out,
  output logic [15:0] gain_out,
  output logic [7:0] active_window_mask_out,
  output logic [4:0] decimation_out,
  output logic [4:0] dark_row_addr_out,
  output logic [4:0] ystart_out,
  output logic [12:0] last_row_out,
  output logic [127:0] window_config_out,
  output logic [239:0] misc_config_out
);
  import fsc_pkg::*;

  // Pending (host visible) registers
  logic [15:0] seq_ctrl;
  logic [15:0] window_select;
  logic [15:0] dark_rows;
  logic [15:0] padding_rows;
  logic [15:0] row_length;
  logic [15:0] gain_lat_ctrl;
  logic [15:0] timer_mult;
  logic [15:0] frame_period;
  logic [15:0] exposure;
  logic [15:0] gain;
  logic [15:0] freeze_ctrl;
  logic [15:0] row_addr;
  logic [15:0] last_row;
  logic [15:0] decimation;
  logic [15:0] misc_reg [N_MISC];
  logic [15:0] win_reg [N_WIN];

  // Active set from the shadow stages
  logic [15:0] act_row_length;
  logic [15:0] act_dark_rows;
  logic [15:0] act_padding_rows;
  logic [47:0] act_exp;
  logic [15:0] gain_staged;
  logic [35:0] act_roi;
  logic [35:0] pend_roi;
  logic wr_misc;
  logic [3:0] misc_idx;
  logic blank_due;

  // Misc (black-level, sync-code, test-pattern) index from address
  always_comb begin
    wr_misc = 1'b0;
    misc_idx = 4'h0;
    if (reg_addr_in >= ADDR_BLACK_FIRST && reg_addr_in <= ADDR_BLACK_LAST) begin
      wr_misc = 1'b1;
      misc_idx = 4'(reg_addr_in - ADDR_BLACK_FIRST);
    end else if (reg_addr_in >= ADDR_TEST_FIRST && reg_addr_in <= ADDR_TEST_LAST) begin
      wr_misc = 1'b1;
      misc_idx = 4'(reg_addr_in - ADDR_TEST_FIRST) + MISC_TEST_BASE;
    end
  end

  // Host writes always land in the pending set; freezing acts on the copy only
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      seq_ctrl <= REG_RESET;
      window_select <= REG_RESET;
      dark_rows <= REG_RESET;
      padding_rows <= REG_RESET;
      row_length <= REG_RESET;
      gain_lat_ctrl <= REG_RESET;
      timer_mult <= REG_RESET;
      frame_period <= REG_RESET;
      exposure <= REG_RESET;
      gain <= REG_RESET;
      freeze_ctrl <= FREEZE_RESET;
      row_addr <= REG_RESET;
      last_row <= REG_RESET;
      decimation <= REG_RESET;
    end else if (reg_wr_in) begin
      unique case (reg_addr_in)
        ADDR_SEQ_CTRL: begin
          seq_ctrl <= reg_wdata_in;
        end
        ADDR_ACTIVE_WINDOW_SELECT: begin
          window_select <= reg_wdata_in;
        end
        ADDR_DARK_ROW_COUNT: begin
          dark_rows <= reg_wdata_in;
        end
        ADDR_PADDING_ROW_COUNT: begin
          padding_rows <= reg_wdata_in;
        end
        ADDR_ROW_LENGTH: begin
          row_length <= reg_wdata_in;
        end
        ADDR_GAIN_LAT_CTRL: begin
          gain_lat_ctrl <= reg_wdata_in;
        end
        ADDR_TIMER_MULT: begin
          timer_mult <= reg_wdata_in;
        end
        ADDR_FRAME_PERIOD: begin
          frame_period <= reg_wdata_in;
        end
        ADDR_EXPOSURE_SETTING: begin
          exposure <= reg_wdata_in;
        end
        ADDR_GAIN_SETTING: begin
          gain <= reg_wdata_in;
        end
        ADDR_UPDATE_FREEZE_CONTROL: begin
          freeze_ctrl <= reg_wdata_in;
        end
        ADDR_ROW_ADDR: begin
          row_addr <= reg_wdata_in;
        end
        ADDR_LAST_ROW: begin
          last_row <= reg_wdata_in;
        end
        ADDR_DECIMATION_MODE: begin
          decimation <= reg_wdata_in;
        end
        default: begin
        end
      endcase
    end
  end

  // Misc registers follow at every frame start, never frozen
  generate
    for (genvar gi = 0; gi < N_MISC; gi++) begin : g_misc
      always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
          misc_reg[gi] <= REG_RESET;
        end else if (reg_wr_in && wr_misc && misc_idx == 4'(gi)) begin
          misc_reg[gi] <= reg_wdata_in;
        end
      end
      // A write mid-frame only shows from the next frame on
      always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
          misc_config_out[gi*16 +: 16] <= REG_RESET;
        end else if (frame_start_in) begin
          misc_config_out[gi*16 +: 16] <= misc_reg[gi];
        end
      end
    end
    for (genvar gi = 0; gi < N_WIN; gi++) begin : g_win
      // Window dimensions bypass the freeze and act at once
      always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
          win_reg[gi] <= REG_RESET;
          window_config_out[gi*16 +: 16] <= REG_RESET;
        end else if (reg_wr_in && reg_addr_in == ADDR_WINDOW_FIRST + 9'(gi)) begin
          win_reg[gi] <= reg_wdata_in;
          window_config_out[gi*16 +: 16] <= reg_wdata_in;
        end
      end
    end
  endgenerate

  // Shadow stages, one per freeze group
  fsc_shadow_stage #(.WIDTH(16)) u_row_len (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .frame_start_in(frame_start_in),
    .follow_in(freeze_ctrl[SYNC_ROW_LEN_BIT]),
    .pending_in(row_length),
    .active_out(act_row_length)
  );
  fsc_shadow_stage #(.WIDTH(16)) u_dark (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .frame_start_in(frame_start_in),
    .follow_in(freeze_ctrl[SYNC_DARK_BIT]),
    .pending_in(dark_rows),
    .active_out(act_dark_rows)
  );
  fsc_shadow_stage #(.WIDTH(16)) u_pad (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .frame_start_in(frame_start_in),
    .follow_in(freeze_ctrl[SYNC_PAD_BIT]),
    .pending_in(padding_rows),
    .active_out(act_padding_rows)
  );
  fsc_shadow_stage #(.WIDTH(48)) u_exp (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .frame_start_in(frame_start_in),
    .follow_in(freeze_ctrl[SYNC_EXP_BIT]),
    .pending_in({timer_mult, frame_period, exposure}),
    .active_out(act_exp)
  );
  fsc_shadow_stage #(.WIDTH(16)) u_gain (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .frame_start_in(frame_start_in),
    .follow_in(freeze_ctrl[SYNC_GAIN_BIT]),
    .pending_in(gain),
    .active_out(gain_staged)
  );

  // ROI group: selection, decimation, row addresses move as one
  assign pend_roi = {window_select[7:0], decimation[4:0], row_addr[9:0], last_row[12:0]};
  fsc_shadow_stage #(.WIDTH(36)) u_roi (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .frame_start_in(frame_start_in),
    .follow_in(freeze_ctrl[SYNC_ROI_BIT]),
    .pending_in(pend_roi),
    .active_out(act_roi)
  );

  // Frame-timing outputs registered so the sequencer sees flops
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      row_length_out <= REG_RESET;
      dark_rows_out <= REG_RESET;
      padding_rows_out <= REG_RESET;
      timer_mult_out <= REG_RESET;
      frame_period_out <= REG_RESET;
      exposure_out <= REG_RESET;
      active_window_mask_out <= 8'h00;
      decimation_out <= 5'h00;
      dark_row_addr_out <= 5'h00;
      ystart_out <= 5'h00;
      last_row_out <= 13'h0000;
    end else begin
      row_length_out <= act_row_length;
      dark_rows_out <= act_dark_rows;
      padding_rows_out <= act_padding_rows;
      {timer_mult_out, frame_period_out, exposure_out} <= act_exp;
      {active_window_mask_out, decimation_out, dark_row_addr_out, ystart_out,
        last_row_out} <= act_roi;
    end
  end

  // Gain: with latency compensation the staged value waits one more frame
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      gain_out <= REG_RESET;
    end else if (frame_start_in) begin
      if (gain_lat_ctrl[GAIN_LAT_BIT]) begin
        gain_out <= gain_staged;
      end else if (freeze_ctrl[SYNC_GAIN_BIT]) begin
        gain_out <= gain;
      end
    end
  end

  // Changes that need more than a frame to settle blank the new frame
  always_comb begin
    blank_due = 1'b0;
    if (freeze_ctrl[SYNC_ROI_BIT] && decimation[4:0] != act_roi[27:23]) begin
      blank_due = 1'b1;
    end
    if ((freeze_ctrl[SYNC_DARK_BIT] && dark_rows != act_dark_rows) ||
        (freeze_ctrl[SYNC_PAD_BIT] && padding_rows != act_padding_rows)) begin
      blank_due = 1'b1;
    end
    // Only a new selection counts; resizing the window does not blank
    if (freeze_ctrl[SYNC_ROI_BIT] && seq_ctrl[BLANK_ROI_BIT] &&
        window_select[7:0] != act_roi[35:28]) begin
      blank_due = 1'b1;
    end
  end

  // Blank flag holds for the whole frame; sequencer sends training then
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      blank_frame_out <= 1'b0;
    end else if (frame_start_in) begin
      blank_frame_out <= blank_due && seq_ctrl[SEQ_EN_BIT];
    end
  end

  // Sequencer enable goes out directly; static regs are host's concern
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      seq_enable_out <= 1'b0;
    end else begin
      seq_enable_out <= seq_ctrl[SEQ_EN_BIT];
    end
  end

  // Read port: pending values, status shows pending and current blanking
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      reg_rdata_out <= REG_RESET;
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rvalid_out <= reg_rd_in;
      if (reg_rd_in) begin
        if (wr_misc) begin
          reg_rdata_out <= misc_reg[misc_idx];
        end else if (reg_addr_in >= ADDR_WINDOW_FIRST && reg_addr_in <= ADDR_WINDOW_LAST) begin
          reg_rdata_out <= win_reg[3'(reg_addr_in - ADDR_WINDOW_FIRST)];
        end else begin
          unique case (reg_addr_in)
            ADDR_SEQ_CTRL: reg_rdata_out <= seq_ctrl;
            ADDR_ACTIVE_WINDOW_SELECT: reg_rdata_out <= window_select;
            ADDR_DARK_ROW_COUNT: reg_rdata_out <= dark_rows;
            ADDR_PADDING_ROW_COUNT: reg_rdata_out <= padding_rows;
            ADDR_ROW_LENGTH: reg_rdata_out <= row_length;
            ADDR_GAIN_LAT_CTRL: reg_rdata_out <= gain_lat_ctrl;
            ADDR_TIMER_MULT: reg_rdata_out <= timer_mult;
            ADDR_FRAME_PERIOD: reg_rdata_out <= frame_period;
            ADDR_EXPOSURE_SETTING: reg_rdata_out <= exposure;
            ADDR_GAIN_SETTING: reg_rdata_out <= gain;
            ADDR_UPDATE_FREEZE_CONTROL: reg_rdata_out <= freeze_ctrl;
            ADDR_STATUS: reg_rdata_out <= {14'h0000, blank_due, blank_frame_out};
            ADDR_ROW_ADDR: reg_rdata_out <= row_addr;
            ADDR_LAST_ROW: reg_rdata_out <= last_row;
            ADDR_DECIMATION_MODE: reg_rdata_out <= decimation;
            default: reg_rdata_out <= REG_RESET;
          endcase
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb/fsc_config_shadow_chk.sv
// Purpose: Port-level timing checks on the shadow register bank
// Assumes: One clock domain, reset_in asynchronous and active high
// Notes: Frame-synced outputs may move only one or two cycles after a frame start; window words follow the write
`timescale 1ns/1ps
`default_nettype none
module fsc_config_shadow_chk (
  // Clock and reset
  input wire logic clock_in,
  input wire logic reset_in,
  // Register port
  input wire logic [fsc_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [fsc_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic reg_rvalid_out,
  // Sequencer side
  input wire logic frame_start_in,
  input wire logic seq_enable_out,
  input wire logic blank_frame_out,
  input wire logic [15:0] row_length_out,
  input wire logic [15:0] dark_rows_out,
  input wire logic [15:0] padding_rows_out,
  input wire logic [15:0] exposure_out,
  input wire logic [15:0] gain_out,
  input wire logic [7:0] active_window_mask_out,
  input wire logic [4:0] decimation_out,
  input wire logic [127:0] window_config_out,
  input wire logic [239:0] misc_config_out
);
  import fsc_pkg::*;
  // All checks share the one clock and drop out during reset
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (reset_in);
  a_read_answer: assert property (reg_rd_in |=> reg_rvalid_out)
    else $error("read strobe not answered one cycle later");
  a_no_stray_valid: assert property (!reg_rd_in |=> !reg_rvalid_out)
    else $error("read valid without a read strobe");
  a_expo_frame_edge: assert property ($changed(exposure_out) |-> $past(frame_start_in, 2))
    else $error("exposure moved away from a frame start");
  a_row_len_held: assert property ($changed(row_length_out) |-> $past(frame_start_in, 2))
    else $error("row length moved away from a frame start");
  a_row_counts_held: assert property (($changed(dark_rows_out) || $changed(padding_rows_out))
    |-> $past(frame_start_in, 2))
    else $error("row counts moved away from a frame start");
  a_roi_set_held: assert property (($changed(active_window_mask_out) || $changed(decimation_out))
    |-> $past(frame_start_in, 2))
    else $error("window selection moved away from a frame start");
  a_gain_frame_edge: assert property ($changed(gain_out) |-> $past(frame_start_in))
    else $error("gain moved away from a frame start");
  a_blank_frame_edge: assert property ($changed(blank_frame_out) |-> $past(frame_start_in))
    else $error("blank level changed inside a frame");
  a_blank_needs_seq: assert property ($rose(blank_frame_out) |-> $past(seq_enable_out))
    else $error("blank raised while the sequencer was off");
  a_window_direct: assert property ((reg_wr_in && reg_addr_in == ADDR_WINDOW_FIRST)
    |=> window_config_out[15:0] == $past(reg_wdata_in))
    else $error("window word not updated one cycle after write");
  a_misc_frame_edge: assert property ($changed(misc_config_out)
    |-> ($past(frame_start_in) || $past(frame_start_in, 2)))
    else $error("misc settings moved away from a frame start");
  // Main scenarios reached
  c_blank: cover property (frame_start_in ##1 blank_frame_out);
  c_read: cover property (reg_rd_in ##1 reg_rvalid_out);
  c_gain: cover property ($changed(gain_out));
endmodule
bind fsc_config_shadow fsc_config_shadow_chk u_chk (
  .clock_in(clock_in), .reset_in(reset_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_rvalid_out(reg_rvalid_out), .frame_start_in(frame_start_in),
  .seq_enable_out(seq_enable_out), .blank_frame_out(blank_frame_out),
  .row_length_out(row_length_out), .dark_rows_out(dark_rows_out),
  .padding_rows_out(padding_rows_out), .exposure_out(exposure_out), .gain_out(gain_out),
  .active_window_mask_out(active_window_mask_out), .decimation_out(decimation_out),
  .window_config_out(window_config_out), .misc_config_out(misc_config_out)
);
`default_nettype wire

// ===== tb/fsc_host_model.sv
// Purpose: Host side that writes and reads the bank registers
// Assumes: Strobes are driven at the falling edge, taken at the rising edge
// Notes: Idle lines carry inverted values so stale data cannot pass for fresh
`timescale 1ns/1ps
`default_nettype none
module fsc_host_model (
  // Clock
  input wire logic clock_in,
  // Register port toward the bank
  output logic [fsc_pkg::ADDR_W-1:0] reg_addr_out,
  output logic [fsc_pkg::DATA_W-1:0] reg_wdata_out,
  output logic reg_wr_out,
  output logic reg_rd_out,
  input wire logic [fsc_pkg::DATA_W-1:0] reg_rdata_in,
  input wire logic reg_rvalid_in
);
  import fsc_pkg::*;
  // Quiet bus at time zero
  initial begin
    reg_addr_out = 9'h1aa;
    reg_wdata_out = 16'ha5a5;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
  end
  // One-cycle write strobe
  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    @(negedge clock_in);
    reg_addr_out = a;
    reg_wdata_out = d;
    reg_wr_out = 1'b1;
    @(negedge clock_in);
    reg_wr_out = 1'b0;
    reg_addr_out = ~a;
    reg_wdata_out = ~d;
  endtask
  // One-cycle read strobe; the answer is awaited under a small bound
  task automatic rd(input logic [8:0] a, output logic [15:0] d, output logic ok);
    @(negedge clock_in);
    reg_addr_out = a;
    reg_rd_out = 1'b1;
    @(negedge clock_in);
    reg_rd_out = 1'b0;
    reg_addr_out = ~a;
    ok = 1'b0;
    d = 16'h0000;
    for (int n = 0; n < 4 && !ok; n++) begin
      if (reg_rvalid_in === 1'b1) begin
        d = reg_rdata_in;
        ok = 1'b1;
      end else begin
        @(negedge clock_in);
      end
    end
  endtask
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Purpose: Self-checking bench for the frame synced shadow bank
// Assumes: Frame starts are one-cycle pulses made here
// Notes: Expectations are fixed values set in the bench, never taken from outputs
`timescale 1ns/1ps
`default_nettype none
module tb;
  import fsc_pkg::*;
  logic clock_in, reset_in, fs;
  logic [8:0] addr;
  logic [15:0] wdata, rdata, rv;
  logic wr, rd, rvalid, seq_en, blank, ok;
  logic [15:0] row_len, dark, pad, expo, gain, tmul, fper;
  logic [7:0] mask;
  logic [4:0] dec, dra, ys;
  logic [12:0] lrow;
  logic [127:0] win;
  logic [239:0] misc;
  int n_mismatch = 0;
  int samples_checked = 0;
  logic [8:0] gaddr [6] = '{ADDR_ROW_LENGTH, ADDR_DARK_ROW_COUNT, ADDR_PADDING_ROW_COUNT,
    ADDR_EXPOSURE_SETTING, ADDR_GAIN_SETTING, ADDR_ACTIVE_WINDOW_SELECT};
  logic [8:0] baddr [3] = '{ADDR_DARK_ROW_COUNT, ADDR_PADDING_ROW_COUNT, ADDR_DECIMATION_MODE};
  fsc_config_shadow dut (.clock_in(clock_in), .reset_in(reset_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .reg_rvalid_out(rvalid), .frame_start_in(fs), .seq_enable_out(seq_en),
    .blank_frame_out(blank), .row_length_out(row_len), .dark_rows_out(dark),
    .padding_rows_out(pad), .timer_mult_out(tmul), .frame_period_out(fper), .exposure_out(expo),
    .gain_out(gain), .active_window_mask_out(mask), .decimation_out(dec),
    .dark_row_addr_out(dra), .ystart_out(ys), .last_row_out(lrow), .window_config_out(win),
    .misc_config_out(misc));
  fsc_host_model host (.clock_in(clock_in), .reg_addr_out(addr), .reg_wdata_out(wdata),
    .reg_wr_out(wr), .reg_rd_out(rd), .reg_rdata_in(rdata), .reg_rvalid_in(rvalid));
  // 40 MHz clock
  initial begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rdchk(input string nm, input logic [8:0] a, input logic [15:0] exp);
    host.rd(a, rv, ok);
    if (ok !== 1'b1) begin
      n_mismatch++;
      wrap_up();
    end else begin
      chk(nm, rv, exp);
    end
  endtask
  // Frame start pulse, then wait until active copies have reached the ports
  task automatic frame();
    @(negedge clock_in);
    fs = 1'b1;
    @(negedge clock_in);
    fs = 1'b0;
    repeat (2) @(negedge clock_in);
  endtask
  function automatic logic [15:0] act(input int i);
    case (i)
      0: act = row_len;
      1: act = dark;
      2: act = pad;
      3: act = expo;
      4: act = gain;
      default: act = {8'h00, mask};
    endcase
  endfunction
  initial begin
    reset_in = 1'b1;
    fs = 1'b0;
    repeat (10) @(negedge clock_in);
    reset_in = 1'b0;
    rdchk("freeze reset", ADDR_UPDATE_FREEZE_CONTROL, FREEZE_RESET);
    host.wr(9'h1ff, 16'hffff);
    rdchk("unmapped", 9'h1ff, 16'h0000);
    chk("seq idle", {15'h0000, seq_en}, 16'h0000);
    // Each group frozen, written, then released; sequencer idle so no blank
    for (int i = 0; i < 6; i++) begin
      host.wr(ADDR_UPDATE_FREEZE_CONTROL, FREEZE_RESET & ~(16'h0001 << i));
      host.wr(gaddr[i], 16'h00a0 + 16'(i));
      frame();
      chk("frozen", act(i), 16'h0000);
      rdchk("stored", gaddr[i], 16'h00a0 + 16'(i));
      host.wr(ADDR_UPDATE_FREEZE_CONTROL, FREEZE_RESET);
      frame();
      chk("released", act(i), 16'h00a0 + 16'(i));
    end
    // Window words bypass the ROI freeze
    host.wr(ADDR_UPDATE_FREEZE_CONTROL, 16'h001f);
    host.wr(ADDR_WINDOW_FIRST, 16'h1234);
    @(negedge clock_in);
    chk("window", win[15:0], 16'h1234);
    host.wr(ADDR_UPDATE_FREEZE_CONTROL, FREEZE_RESET);
    // Gain latency compensation adds one frame
    host.wr(ADDR_GAIN_SETTING, 16'h0111);
    frame();
    chk("gain", gain, 16'h0111);
    host.wr(ADDR_GAIN_LAT_CTRL, 16'h2000);
    rdchk("gain lat", ADDR_GAIN_LAT_CTRL, 16'h2000);
    host.wr(ADDR_GAIN_SETTING, 16'h0222);
    frame();
    chk("gain late", gain, 16'h0111);
    frame();
    chk("gain aligned", gain, 16'h0222);
    host.wr(ADDR_GAIN_LAT_CTRL, 16'h0000);
    // Test pattern and sync code words wait for the frame start
    host.wr(ADDR_TEST_FIRST, 16'h0bee);
    host.wr(ADDR_BLACK_FIRST + 9'h002, 16'h0c0d);
    chk("test early", misc[143:128], 16'h0000);
    frame();
    chk("test", misc[143:128], 16'h0bee);
    chk("sync code", misc[47:32], 16'h0c0d);
    // Sequencer running: row count and decimation changes blank one frame
    host.wr(ADDR_SEQ_CTRL, 16'h0001);
    for (int j = 0; j < 3; j++) begin
      host.wr(baddr[j], 16'h0003 + 16'(j));
      frame();
      chk("blank", {15'h0000, blank}, 16'h0001);
      frame();
      chk("unblank", {15'h0000, blank}, 16'h0000);
    end
    chk("decimation", {11'h000, dec}, 16'h0005);
    chk("seq enable", {15'h0000, seq_en}, 16'h0001);
    // Host follows a decimation change with the row addresses
    host.wr(ADDR_ROW_ADDR, 16'h0123);
    host.wr(ADDR_LAST_ROW, 16'h0abc);
    frame();
    chk("row addr", {6'h00, dra, ys}, 16'h0123);
    chk("last row", {3'h0, lrow}, 16'h0abc);
    host.wr(ADDR_TIMER_MULT, 16'h0011);
    host.wr(ADDR_FRAME_PERIOD, 16'h0022);
    host.wr(ADDR_EXPOSURE_SETTING, 16'h0777);
    frame();
    chk("timer mult", tmul, 16'h0011);
    chk("frame period", fper, 16'h0022);
    chk("expo blank", {15'h0000, blank}, 16'h0000);
    chk("expo", expo, 16'h0777);
    host.wr(ADDR_ACTIVE_WINDOW_SELECT, 16'h0003);
    frame();
    chk("roi no blank", {15'h0000, blank}, 16'h0000);
    host.wr(ADDR_SEQ_CTRL, 16'h0201);
    host.wr(ADDR_ACTIVE_WINDOW_SELECT, 16'h0005);
    frame();
    chk("roi blank", {15'h0000, blank}, 16'h0001);
    frame();
    host.wr(ADDR_WINDOW_FIRST, 16'h4321);
    frame();
    chk("resize blank", {15'h0000, blank}, 16'h0000);
    wrap_up();
  end
endmodule
`default_nettype wire
